//--- verilog/epic_top.sv
// External pin interrupt controller with vector selection and AHB-Lite regs
//
// Function
// RULE_01: Pin requests 0,1 use vectors 0x001, 0x002
// RULE_02: Toggle groups 0..3 use vectors 0x003..0x006
// RULE_03: Peripheral requests map to 0x007..0x013 in order
// RULE_04: Disabled sources never produce a vector
// RULE_05: Requests raised even when pins drive outputs
// RULE_06: Group n counts toggles on its selected inputs
// RULE_07: Per-group select registers pick contributing pins
// RULE_08: Pin changes detected without clock for wake
// RULE_09: Level sense requests while pin stays low
// RULE_10: Edge detection only with running clock
// RULE_11: Low level detected asynchronously for wake
// RULE_12: Driver holds level until start-up ends
// RULE_13: Level gone early: wake, but no request
// RULE_14: Sense register bits 7:4 read zero
// RULE_15: Pin 1 needs global and own enable
// RULE_16: Pin sampled first; pulses over one clock caught
// RULE_17: Driver holds low until instruction completes
// RULE_18: Pin 1 sense bits 3:2 select mode
// RULE_19: Pin 0 sense bits 1:0, same encoding
// RULE_20: Pending flag zero in level sense
// RULE_21: Edge flag cleared on entry or write-one
// RULE_22: Lowest vector number wins among pending
// RULE_23: Sense fields reset to zero, low level
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module epic_top (
  input  wire logic        hclk,              // Bus and I/O clock, 250 MHz
  input  wire logic        hresetn,           // Async reset, active low
  input  wire logic        hsel,              // Slave select
  input  wire logic [31:0] haddr,             // Byte address
  input  wire logic [1:0]  htrans,            // Transfer type
  input  wire logic        hwrite,            // Write when high
  input  wire logic [2:0]  hsize,             // Transfer size
  input  wire logic [31:0] hwdata,            // Write data
  input  wire logic        hready,            // Bus ready in
  output logic             hreadyout,         // Always ready
  output logic             hresp,             // Always OKAY
  output logic      [31:0] hrdata,            // Read data
  input  wire logic [1:0]  ext_request_pin,   // Dedicated request pins
  input  wire logic [27:0] toggle_watch_inputs, // Pin-change inputs
  input  wire logic [12:0] periph_req,        // Enabled peripheral levels
  input  wire logic        global_irq_enable, // Global enable from core
  input  wire logic        vector_ack,        // Core fetched irq_vector
  output logic             irq_req,           // Request to core
  output logic      [4:0]  irq_vector,        // Vector program address
  output logic             wake_req           // Clockless wake request
);

  // Lowest set bit of the pending set, as an index
  function automatic logic [4:0] first_set(input logic [18:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = epic_pkg::N_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // Next flag value: hardware set wins over software or ack clear
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic clr);
    return set | (cur & ~clr);
  endfunction

  logic [3:0]  sense_q;
  logic [1:0]  ext_mask_q;
  logic [1:0]  ext_flag_q;
  logic [3:0]  grp_en_q;
  logic [3:0]  grp_flag_q;
  logic [27:0] grp_sel_q;
  logic [1:0]  ext_s1_q, ext_s2_q, ext_prev_q;
  logic [27:0] tog_s1_q, tog_s2_q, tog_prev_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] rdata_q;
  logic        irq_req_q;
  logic [4:0]  irq_vec_q;

  logic [1:0]  sense0, sense1;
  logic [1:0]  ext_level, ext_set, ext_clr, ext_req;
  logic [3:0]  grp_set, grp_clr;
  logic [27:0] tog_change, grp_sel_en;
  logic [18:0] pending;
  logic        addr_ok, wr_now;
  logic [4:0]  win_idx;

  assign sense0 = sense_q[epic_pkg::SENSE0_LSB +: 2];
  assign sense1 = sense_q[epic_pkg::SENSE1_LSB +: 2];

  // Two-flop synchronisers, then a previous-sample stage for edges
  // RULE_16 pins sampled before edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_q   <= 2'h3;
      ext_s2_q   <= 2'h3;
      ext_prev_q <= 2'h3;
      tog_s1_q   <= 28'h0000000;
      tog_s2_q   <= 28'h0000000;
      tog_prev_q <= 28'h0000000;
    end else begin
      ext_s1_q   <= ext_request_pin;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      tog_s1_q   <= toggle_watch_inputs;
      tog_s2_q   <= tog_s1_q;
      tog_prev_q <= tog_s2_q;
    end
  end

  // Edge set terms per sense mode; level mode sets nothing
  // RULE_18 pin 1 sense decode
  // RULE_19 pin 0 sense decode
  // RULE_10 edges need the clock
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      case (k == 0 ? sense0 : sense1)
        epic_pkg::SENSE_ANY:  ext_set[k] = ext_s2_q[k] ^ ext_prev_q[k];
        epic_pkg::SENSE_FALL: ext_set[k] = ~ext_s2_q[k] & ext_prev_q[k];
        epic_pkg::SENSE_RISE: ext_set[k] = ext_s2_q[k] & ~ext_prev_q[k];
        default:              ext_set[k] = 1'b0;
      endcase
    end
  end

  // RULE_09 level request while low
  // RULE_13 early release gives no request
  assign ext_level[0] = (sense0 == epic_pkg::SENSE_LOW);
  assign ext_level[1] = (sense1 == epic_pkg::SENSE_LOW);

  // Per-pin group enable, expanded from the four group enables
  assign grp_sel_en = grp_sel_q & {{4{grp_en_q[3]}}, {8{grp_en_q[2]}},
                                   {8{grp_en_q[1]}}, {8{grp_en_q[0]}}};

  // RULE_07 select masks gate toggles
  assign tog_change = (tog_s2_q ^ tog_prev_q) & grp_sel_q;

  // RULE_06 group slices 27:24..7:0
  assign grp_set[0] = |tog_change[7:0];
  assign grp_set[1] = |tog_change[15:8];
  assign grp_set[2] = |tog_change[23:16];
  assign grp_set[3] = |tog_change[27:24];

  // Bus address phase capture
  assign addr_ok = hsel & htrans[1] & hready;
  assign wr_now  = wr_pend_q;

  // Clears from write-one and from vector acknowledge
  // RULE_21 clear on entry or write-one
  always_comb begin
    ext_clr = 2'h0;
    grp_clr = 4'h0;
    if (wr_now && wr_addr_q == epic_pkg::OFF_EXT_FLAG) begin
      ext_clr = hwdata[1:0];
    end
    if (wr_now && wr_addr_q == epic_pkg::OFF_GRP_FLAG) begin
      grp_clr = hwdata[3:0];
    end
    if (vector_ack && irq_req_q) begin
      if (irq_vec_q == epic_pkg::VEC_EXT0) begin
        ext_clr[0] = 1'b1;
      end
      if (irq_vec_q == epic_pkg::VEC_EXT1) begin
        ext_clr[1] = 1'b1;
      end
      if (irq_vec_q >= epic_pkg::VEC_GRP0 &&
          irq_vec_q <= epic_pkg::VEC_GRP3) begin
        grp_clr[2'(irq_vec_q - epic_pkg::VEC_GRP0)] = 1'b1;
      end
    end
  end

  // Pending flags for edge-sensed pins and toggle groups
  // RULE_20 level mode holds flag zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_flag_q <= 2'h0;
      grp_flag_q <= 4'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        ext_flag_q[k] <= ext_level[k] ? 1'b0 :
                         flag_next(ext_flag_q[k], ext_set[k], ext_clr[k]);
      end
      for (int g = 0; g < 4; g++) begin
        grp_flag_q[g] <= flag_next(grp_flag_q[g], grp_set[g], grp_clr[g]);
      end
    end
  end

  // Requests of the dedicated pins, gated by their mask bits
  // RULE_05 pin state counts, not direction
  assign ext_req = ext_mask_q & ((ext_level & ~ext_s2_q) |
                                 (~ext_level & ext_flag_q));

  // Pending set in vector order; index i is program address i+1
  // RULE_01 pins at 0x001, 0x002
  // RULE_02 groups at 0x003..0x006
  // RULE_03 peripherals at 0x007..0x013
  // RULE_04 only enabled sources pend
  assign pending = {periph_req, grp_flag_q & grp_en_q, ext_req};

  // RULE_22 lowest vector first
  assign win_idx = first_set(pending);

  // Request to the core, gated by the global enable; the vector is not gated
  // RULE_15 global and own enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req_q <= 1'b0;
      irq_vec_q <= 5'h00;
    end else begin
      irq_req_q <= global_irq_enable & (|pending) &
                   ~(vector_ack & irq_req_q);
      irq_vec_q <= (|pending) ? 5'(win_idx + 5'h01) : 5'h00;
    end
  end

  // Clockless wake: raw low levels and raw changes against last sample
  // RULE_08 async pin change wake
  // RULE_11 async low level wake
  assign wake_req = |(ext_mask_q & ext_level & ~ext_request_pin) |
                    |((toggle_watch_inputs ^ tog_prev_q) & grp_sel_en);

  // Address phase is held for the single-cycle data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      wr_addr_q <= addr_ok ? haddr[7:0] : wr_addr_q;
    end
  end

  // Register writes in the data phase
  // RULE_23 sense fields reset zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_q    <= epic_pkg::SENSE_RST;
      ext_mask_q <= epic_pkg::EXT_MASK_RST;
      grp_en_q   <= epic_pkg::GRP_EN_RST;
      grp_sel_q  <= epic_pkg::GRP_SEL_RST;
    end else if (wr_now) begin
      case (wr_addr_q)
        epic_pkg::OFF_SENSE_CFG:  sense_q    <= hwdata[3:0];
        epic_pkg::OFF_EXT_MASK:   ext_mask_q <= hwdata[1:0];
        epic_pkg::OFF_GRP_ENABLE: grp_en_q   <= hwdata[3:0];
        epic_pkg::OFF_GRP_SEL0:   grp_sel_q[7:0]   <= hwdata[7:0];
        epic_pkg::OFF_GRP_SEL1:   grp_sel_q[15:8]  <= hwdata[7:0];
        epic_pkg::OFF_GRP_SEL2:   grp_sel_q[23:16] <= hwdata[7:0];
        epic_pkg::OFF_GRP_SEL3:   grp_sel_q[27:24] <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  // Read data captured at the address phase; unmapped reads zero
  // RULE_14 upper sense bits read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        epic_pkg::OFF_SENSE_CFG:  rdata_q <= {28'h0000000, sense_q};
        epic_pkg::OFF_EXT_MASK:   rdata_q <= {30'h00000000, ext_mask_q};
        epic_pkg::OFF_EXT_FLAG:   rdata_q <= {30'h00000000, ext_flag_q};
        epic_pkg::OFF_GRP_ENABLE: rdata_q <= {28'h0000000, grp_en_q};
        epic_pkg::OFF_GRP_FLAG:   rdata_q <= {28'h0000000, grp_flag_q};
        epic_pkg::OFF_GRP_SEL0:   rdata_q <= {24'h000000, grp_sel_q[7:0]};
        epic_pkg::OFF_GRP_SEL1:   rdata_q <= {24'h000000, grp_sel_q[15:8]};
        epic_pkg::OFF_GRP_SEL2:   rdata_q <= {24'h000000, grp_sel_q[23:16]};
        epic_pkg::OFF_GRP_SEL3:   rdata_q <= {28'h0000000, grp_sel_q[27:24]};
        epic_pkg::OFF_IRQ_STATUS: rdata_q <= {23'h000000, irq_req_q,
                                              3'h0, irq_vec_q};
        default:                  rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Bus answers: zero wait states, always OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = rdata_q;
  assign irq_req    = irq_req_q;
  assign irq_vector = irq_vec_q;

  // Size is ignored: only whole-word transfers are expected
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:8]};
endmodule
`default_nettype wire

//--- verilog/epic_pkg.sv
// Constants for the external pin interrupt controller
package epic_pkg;
  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFF_SENSE_CFG  = 8'h00;
  localparam logic [7:0] OFF_EXT_MASK   = 8'h04;
  localparam logic [7:0] OFF_EXT_FLAG   = 8'h08;
  localparam logic [7:0] OFF_GRP_ENABLE = 8'h0c;
  localparam logic [7:0] OFF_GRP_FLAG   = 8'h10;
  localparam logic [7:0] OFF_GRP_SEL0   = 8'h14;
  localparam logic [7:0] OFF_GRP_SEL1   = 8'h18;
  localparam logic [7:0] OFF_GRP_SEL2   = 8'h1c;
  localparam logic [7:0] OFF_GRP_SEL3   = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
  // Sense field positions inside the sense configuration register
  localparam int SENSE0_LSB = 0;
  localparam int SENSE1_LSB = 2;
  localparam int SENSE_W    = 4;
  // Sense encodings, shared by both dedicated pins
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_ANY  = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  // Reset values
  localparam logic [3:0] SENSE_RST  = 4'h0;
  localparam logic [1:0] EXT_MASK_RST = 2'h0;
  localparam logic [3:0] GRP_EN_RST = 4'h0;
  localparam logic [27:0] GRP_SEL_RST = 28'h0000000;
  // Vector program addresses
  localparam logic [4:0] VEC_EXT0   = 5'h01;
  localparam logic [4:0] VEC_EXT1   = 5'h02;
  localparam logic [4:0] VEC_GRP0   = 5'h03;
  localparam logic [4:0] VEC_GRP3   = 5'h06;
  localparam logic [4:0] VEC_PERIPH = 5'h07;
  localparam logic [4:0] VEC_LAST   = 5'h13;
  // Source counts
  localparam int N_PERIPH = 13;
  localparam int N_SRC    = 19;
  localparam int N_WATCH  = 28;
  // Status register field positions
  localparam int STAT_REQ_BIT = 8;
endpackage

//--- tb/epic_checker.sv
// Port checker for the pin interrupt controller
`timescale 1ns/1ps
`default_nettype none
module epic_checker (
  input wire logic        hclk,              // Clock
  input wire logic        hresetn,           // Reset, active low
  input wire logic        hsel,              // Slave select
  input wire logic [31:0] haddr,             // Byte address
  input wire logic [1:0]  htrans,            // Transfer type
  input wire logic        hwrite,            // Write when high
  input wire logic        hready,            // Bus ready in
  input wire logic        hreadyout,         // Ready out
  input wire logic        hresp,             // Response
  input wire logic [31:0] hrdata,            // Read data
  input wire logic [12:0] periph_req,        // Peripheral levels
  input wire logic        global_irq_enable, // Global enable
  input wire logic        vector_ack,        // Core fetch pulse
  input wire logic        irq_req,           // Request to core
  input wire logic [4:0]  irq_vector         // Offered vector
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read address phase taken
  wire logic rd_go = hsel && htrans[1] && hready && !hwrite;
  sequence prio_held;
    (periph_req[0] && global_irq_enable && !vector_ack)[*3];
  endsequence
  sequence cfg_read;
    rd_go && haddr[7:0] == epic_pkg::OFF_SENSE_CFG;
  endsequence
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  cfg_rsvd_a: assert property (cfg_read |=> hrdata[31:4] == 28'h0)
    else $error("sense upper bits not zero");
  unmapped_a: assert property (rd_go && haddr[7:0] == 8'h28 |=> !hrdata)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!rd_go |=> $stable(hrdata))
    else $error("read data moved without read");
  ack_drop_a: assert property (irq_req && vector_ack |=> !irq_req)
    else $error("request stayed after fetch");
  vec_range_a: assert property (irq_req |-> irq_vector >= 5'h01 &&
    irq_vector <= epic_pkg::VEC_LAST) else $error("vector out of range");
  glob_gate_a: assert property (!global_irq_enable [*2] |-> !irq_req)
    else $error("request without global enable");
  lowest_wins_a: assert property (prio_held |-> irq_req &&
    irq_vector <= epic_pkg::VEC_PERIPH) else $error("priority lost");
endmodule
bind epic_top epic_checker i_epic_checker (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .periph_req(periph_req), .global_irq_enable(global_irq_enable),
  .vector_ack(vector_ack), .irq_req(irq_req), .irq_vector(irq_vector));
`default_nettype wire

//--- tb/epic_core_model.sv
// Core model that fetches vectors from the controller
`timescale 1ns/1ps
`default_nettype none
module epic_core_model (
  input  wire logic       hclk,       // Clock
  input  wire logic       hresetn,    // Reset, active low
  input  wire logic       ack_en,     // Fetch allowed, no fetch when low
  input  wire logic       irq_req,    // Request from controller
  input  wire logic [4:0] irq_vector, // Offered vector
  output logic            vector_ack, // Fetch pulse
  output logic      [4:0] taken_vec,  // Last fetched vector
  output logic      [7:0] taken_cnt   // Fetch count
);
  // Single-cycle fetch pulse while requested, never in two cycles in a row
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vector_ack <= 1'b0;
      taken_vec  <= 5'h00;
      taken_cnt  <= 8'h00;
    end else begin
      vector_ack <= irq_req && ack_en && !vector_ack;
      if (vector_ack && irq_req) begin
        taken_vec <= irq_vector;
        taken_cnt <= taken_cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Register and request tests for the pin interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0, ext_request_pin = 2'h3;
  logic [2:0]  hsize = 3'h2;
  logic [27:0] toggle_watch_inputs = 28'h0;
  logic [12:0] periph_req = 13'h0;
  logic        global_irq_enable = 1'b1, ack_en = 1'b0;
  wire logic   hready, hreadyout, hresp, vector_ack, irq_req, wake_req;
  wire logic [31:0] hrdata;
  wire logic [4:0]  irq_vector, taken_vec;
  wire logic [7:0]  taken_cnt;
  int          n_errors = 0, total_checks = 0;
  assign hready = hreadyout;
  // Clock at 4 ns
  always #2 hclk = ~hclk;
  epic_top i_epic_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ext_request_pin(ext_request_pin),
    .toggle_watch_inputs(toggle_watch_inputs), .periph_req(periph_req),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
    .irq_req(irq_req), .irq_vector(irq_vector), .wake_req(wake_req));
  epic_core_model i_epic_core_model (.hclk(hclk), .hresetn(hresetn),
    .ack_en(ack_en), .irq_req(irq_req), .irq_vector(irq_vector),
    .vector_ack(vector_ack), .taken_vec(taken_vec), .taken_cnt(taken_cnt));
  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task automatic edge_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      complete_run();
    end
  endtask
  // One AHB-Lite single word transfer
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    edge_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Let the core fetch once, bounded
  task automatic fetch(input logic [4:0] e);
    int k;
    logic [7:0] c0;
    c0 = taken_cnt;
    k = 0;
    ack_en <= 1'b1;
    while (taken_cnt === c0 && k < 50) begin
      @(posedge hclk);
      k++;
    end
    ack_en <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      complete_run();
    end
    chk("fetched vector", {27'h0, e}, {27'h0, taken_vec});
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("sense reset", epic_pkg::OFF_SENSE_CFG, 32'h0);
    xfer(1'b1, epic_pkg::OFF_SENSE_CFG, 32'hff);
    rdc("sense upper", epic_pkg::OFF_SENSE_CFG, 32'hf);
    rdc("unmapped", 8'h28, 32'h0);
    $display("Test registers done");
    // Pin 0 falling edge, pin 1 low level
    xfer(1'b1, epic_pkg::OFF_SENSE_CFG, 32'h2);
    xfer(1'b1, epic_pkg::OFF_EXT_MASK, 32'h1);
    ext_request_pin <= 2'h2;
    idle(8);
    rdc("pin0 status", epic_pkg::OFF_IRQ_STATUS, 32'h101);
    rdc("pin0 flag", epic_pkg::OFF_EXT_FLAG, 32'h1);
    fetch(epic_pkg::VEC_EXT0);
    rdc("pin0 cleared", epic_pkg::OFF_EXT_FLAG, 32'h0);
    ext_request_pin <= 2'h3;
    idle(8);
    rdc("pin0 rise", epic_pkg::OFF_EXT_FLAG, 32'h0);
    $display("Test edge done");
    global_irq_enable <= 1'b0;
    xfer(1'b1, epic_pkg::OFF_EXT_MASK, 32'h2);
    // Pin held low well past the detection latency
    // low held through wake
    ext_request_pin <= 2'h1;
    idle(8);
    // Vector still names the source; only the request is gated
    rdc("no global", epic_pkg::OFF_IRQ_STATUS, 32'h2);
    chk("wake level", 32'h1, {31'h0, wake_req});
    global_irq_enable <= 1'b1;
    idle(4);
    rdc("level req", epic_pkg::OFF_IRQ_STATUS, 32'h102);
    rdc("level flag", epic_pkg::OFF_EXT_FLAG, 32'h0);
    ext_request_pin <= 2'h3;
    idle(8);
    rdc("level gone", epic_pkg::OFF_IRQ_STATUS, 32'h0);
    chk("wake idle", 32'h0, {31'h0, wake_req});
    $display("Test level done");
    xfer(1'b1, epic_pkg::OFF_GRP_SEL2, 32'h1);
    xfer(1'b1, epic_pkg::OFF_GRP_ENABLE, 32'h4);
    toggle_watch_inputs <= 28'h0020000;
    idle(8);
    rdc("unselected", epic_pkg::OFF_IRQ_STATUS, 32'h0);
    toggle_watch_inputs <= 28'h0030000;
    idle(1);
    // Raw change against the last sample, before the sync stages catch up
    chk("wake toggle", 32'h1, {31'h0, wake_req});
    idle(7);
    rdc("group2", epic_pkg::OFF_IRQ_STATUS, 32'h105);
    fetch(5'h05);
    xfer(1'b1, epic_pkg::OFF_GRP_ENABLE, 32'h0);
    toggle_watch_inputs <= 28'h0020000;
    idle(8);
    rdc("disabled", epic_pkg::OFF_IRQ_STATUS, 32'h0);
    xfer(1'b1, epic_pkg::OFF_GRP_FLAG, 32'hf);
    xfer(1'b1, epic_pkg::OFF_GRP_SEL3, 32'h8);
    xfer(1'b1, epic_pkg::OFF_GRP_ENABLE, 32'h8);
    toggle_watch_inputs <= 28'h8020000;
    idle(8);
    fetch(epic_pkg::VEC_GRP3);
    $display("Test groups done");
    periph_req <= 13'h0002;
    idle(4);
    rdc("periph", epic_pkg::OFF_IRQ_STATUS, 32'h108);
    xfer(1'b1, epic_pkg::OFF_EXT_MASK, 32'h1);
    ext_request_pin <= 2'h2;
    idle(8);
    rdc("lowest", epic_pkg::OFF_IRQ_STATUS, 32'h101);
    xfer(1'b1, epic_pkg::OFF_EXT_FLAG, 32'h1);
    idle(2);
    rdc("write one", epic_pkg::OFF_IRQ_STATUS, 32'h108);
    // Lowest peripheral line joins; it must win over the timer line
    periph_req <= 13'h0003;
    idle(4);
    rdc("watchdog", epic_pkg::OFF_IRQ_STATUS, 32'h107);
    periph_req <= 13'h0;
    $display("Test priority done");
    complete_run();
  end
endmodule
`default_nettype wire
